// *** shared/ecsr_map.vh ***
// register map, field layout, reset values and timing constants
// for the endpoint identifier register bank.
// assumes a 25 MHz register clock and word-aligned byte addresses.
//
// Functional notes
// - reserved fields of base-high, identifier and lock words read zero
// - base-high bits 30..15 hold address bits 66..51 only in 66-bit mode
// - base-high bits 14..0 hold address bits 50..36 in 50 and 66-bit modes
// - base-low bit 31 reserved in 34-bit mode, address bit 35 otherwise
// - base-low bits 30..0 hold low address bits down to bit 4
// - identifier bits 23..16: writable small node id, resets to all ones
// - identifier bits 15..0: writable wide node id, resets to all ones
// - host owner id is write-once until reset
// - software tag is a full 32-bit read/write word, reset zero
// - block header bits 31..16 are a constant next-block pointer
// - header kind bits 15..0: 1 endpoint, 2 assisted recovery, 3 switch
// - link time-out word at 1120h, count in bits 31..8, low byte zero
// - link time-out lasts count ticks of 205 ns rounded up to 6 cycles (240 ns), zero disables the timer
`ifndef ECSR_MAP_VH
`define ECSR_MAP_VH

// ***************************************************************
// register offsets (byte addresses)
// ***************************************************************
`define ECSR_OFS_BASE_HIGH   16'h1058
`define ECSR_OFS_BASE_LOW    16'h105C
`define ECSR_OFS_NODE_ID     16'h1060
`define ECSR_OFS_HOST_LOCK   16'h1068
`define ECSR_OFS_SW_TAG      16'h106C
`define ECSR_OFS_BLK_HEADER  16'h1100
`define ECSR_OFS_LINK_TO     16'h1120
`define ECSR_OFS_LINK_STAT   16'h1130

// ***************************************************************
// reset values
// ***************************************************************
`define ECSR_RST_BASE        32'h00000000
`define ECSR_RST_SMALL_ID    8'hFF
`define ECSR_RST_WIDE_ID     16'hFFFF
`define ECSR_RST_HOST_ID     16'h0FFF
`define ECSR_RST_SW_TAG      32'h00000000
`define ECSR_RST_LINK_TO     24'hFFFFFF

// ***************************************************************
// hard-wired header contents
// ***************************************************************
`define ECSR_NEXT_BLOCK_PTR  16'h0000
`define ECSR_KIND_ENDPOINT   16'h0001
`define ECSR_KIND_ASSISTED   16'h0002
`define ECSR_KIND_SWITCH     16'h0003

// ***************************************************************
// addressing modes and field masks
// ***************************************************************
`define ECSR_MODE_34         3'h1
`define ECSR_MODE_50         3'h2
`define ECSR_MODE_66         3'h4
`define ECSR_HI_MASK_66      32'h7FFFFFFF
`define ECSR_HI_MASK_50      32'h00007FFF
`define ECSR_LO_MASK_34      32'h7FFFFFFF
`define ECSR_LO_MASK_WIDE    32'hFFFFFFFF
`define ECSR_ZERO_WORD       32'h00000000

// ***************************************************************
// link time-out timing
// ***************************************************************
`define ECSR_TICK_NS         205
`define ECSR_CLK_NS          40
`define ECSR_TICK_CYC        ((`ECSR_TICK_NS + `ECSR_CLK_NS - 1) / `ECSR_CLK_NS)
`define ECSR_ONE_CNT         24'h000001
`define ECSR_ZERO_CNT        24'h000000
`define ECSR_ZERO_DIV        3'h0

`endif

// *** logic/ecsr_bank.v ***
// endpoint identifier and link time-out register bank.
// assumes a single-cycle strobe master on mclk and an addressing mode
// input driven by logic in the same clock domain.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`include "ecsr_map.vh"

module ecsr_bank (
   // clock and reset
   input  wire        mclk,
   input  wire        reset,
   // register port
   input  wire [15:0] addr,
   input  wire [31:0] wr_data,
   input  wire        wr_stb,
   input  wire        rd_stb,
   output reg  [31:0] rd_data_ff,
   // element configuration
   input  wire [2:0]  addr_mode,
   input  wire        wide_id_supported,
   input  wire [15:0] feature_block_kind,
   // link event timing
   input  wire        link_evt_start,
   input  wire        link_evt_done,
   output reg         link_timeout_ff,
   // register contents toward the element
   output reg  [31:0] config_space_base_high_ff,
   output reg  [31:0] config_space_base_low_ff,
   output reg  [7:0]  small_node_id_ff,
   output reg  [15:0] wide_node_id_ff,
   output reg  [15:0] host_owner_id_ff,
   output reg         host_locked_ff,
   output reg  [31:0] software_unit_tag_ff,
   output reg  [23:0] link_timeout_count_ff
);

   // ***************************************************************
   // decode
   // ***************************************************************
   wire sel_hi   = (addr == `ECSR_OFS_BASE_HIGH);
   wire sel_lo   = (addr == `ECSR_OFS_BASE_LOW);
   wire sel_id   = (addr == `ECSR_OFS_NODE_ID);
   wire sel_lock = (addr == `ECSR_OFS_HOST_LOCK);
   wire sel_tag  = (addr == `ECSR_OFS_SW_TAG);
   wire sel_head = (addr == `ECSR_OFS_BLK_HEADER);
   wire sel_to   = (addr == `ECSR_OFS_LINK_TO);
   wire sel_stat = (addr == `ECSR_OFS_LINK_STAT);

   // ***************************************************************
   // addressing-mode masks
   // ***************************************************************
   reg [31:0] hi_mask;
   reg [31:0] lo_mask;

   always @* begin
      case (addr_mode)
         `ECSR_MODE_66: begin
            hi_mask = `ECSR_HI_MASK_66;
            lo_mask = `ECSR_LO_MASK_WIDE;
         end
         `ECSR_MODE_50: begin
            hi_mask = `ECSR_HI_MASK_50;
            lo_mask = `ECSR_LO_MASK_WIDE;
         end
         default: begin
            // reserved encodings act as the narrowest mode
            hi_mask = `ECSR_ZERO_WORD;
            lo_mask = `ECSR_LO_MASK_34;
         end
      endcase
   end

   // ***************************************************************
   // writable registers
   // ***************************************************************
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         config_space_base_high_ff <= `ECSR_RST_BASE;
         config_space_base_low_ff  <= `ECSR_RST_BASE;
         small_node_id_ff          <= `ECSR_RST_SMALL_ID;
         wide_node_id_ff           <= `ECSR_RST_WIDE_ID;
         host_owner_id_ff          <= `ECSR_RST_HOST_ID;
         host_locked_ff            <= 1'b0;
         software_unit_tag_ff      <= `ECSR_RST_SW_TAG;
         link_timeout_count_ff     <= `ECSR_RST_LINK_TO;
      end else if (wr_stb) begin
         // reserved and mode-hidden bits are dropped
         if (sel_hi) begin
            config_space_base_high_ff <= wr_data & hi_mask;
         end
         if (sel_lo) begin
            config_space_base_low_ff <= wr_data & lo_mask;
         end
         if (sel_id) begin
            small_node_id_ff <= wr_data[23:16];
            wide_node_id_ff  <= wr_data[15:0];
         end
         // only the first write after reset sticks
         if (sel_lock && !host_locked_ff) begin
            host_owner_id_ff <= wr_data[15:0];
            host_locked_ff   <= 1'b1;
         end
         if (sel_tag) begin
            software_unit_tag_ff <= wr_data;
         end
         if (sel_to) begin
            link_timeout_count_ff <= wr_data[31:8];
         end
      end
   end

   // ***************************************************************
   // link time-out timer
   // ***************************************************************
   // one tick per 205 ns, rounded up to whole cycles; a count of n
   // therefore expires after n ticks, never early
   reg  [2:0]  div_ff;
   reg  [23:0] left_ff;
   reg         run_ff;
   reg         expired_ff;
   reg  [2:0]  nxt_div;
   reg  [23:0] nxt_left;
   reg         nxt_run;
   reg         nxt_timeout;
   wire        tick = run_ff && (div_ff == (`ECSR_TICK_CYC - 1));

   always @* begin
      nxt_div     = div_ff;
      nxt_left    = left_ff;
      nxt_run     = run_ff;
      nxt_timeout = 1'b0;
      if (link_evt_done) begin
         nxt_run = 1'b0;
         nxt_div = `ECSR_ZERO_DIV;
      end else if (link_evt_start) begin
         // zero count keeps the timer idle
         nxt_run  = (link_timeout_count_ff != `ECSR_ZERO_CNT);
         nxt_left = link_timeout_count_ff;
         nxt_div  = `ECSR_ZERO_DIV;
      end else if (run_ff) begin
         if (tick) begin
            nxt_div = `ECSR_ZERO_DIV;
            if (left_ff == `ECSR_ONE_CNT) begin
               nxt_run     = 1'b0;
               nxt_timeout = 1'b1;
            end
            nxt_left = left_ff - `ECSR_ONE_CNT;
         end else begin
            nxt_div = div_ff + 3'h1;
         end
      end
   end

   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         div_ff          <= `ECSR_ZERO_DIV;
         left_ff         <= `ECSR_ZERO_CNT;
         run_ff          <= 1'b0;
         link_timeout_ff <= 1'b0;
         expired_ff      <= 1'b0;
      end else begin
         div_ff          <= nxt_div;
         left_ff         <= nxt_left;
         run_ff          <= nxt_run;
         link_timeout_ff <= nxt_timeout;
         // sticky; a new expiry wins over a clear in the same cycle
         if (nxt_timeout) begin
            expired_ff <= 1'b1;
         end else if (wr_stb && sel_stat && wr_data[0]) begin
            expired_ff <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // read path
   // ***************************************************************
   reg [31:0] nxt_rd;

   always @* begin
      nxt_rd = `ECSR_ZERO_WORD;
      case (1'b1)
         sel_hi:   nxt_rd = config_space_base_high_ff & hi_mask;
         sel_lo:   nxt_rd = config_space_base_low_ff & lo_mask;
         sel_id:   nxt_rd = {8'h00, small_node_id_ff,
                             wide_node_id_ff};
         sel_lock: nxt_rd = {16'h0000, host_owner_id_ff};
         sel_tag:  nxt_rd = software_unit_tag_ff;
         sel_head: nxt_rd = {`ECSR_NEXT_BLOCK_PTR,
                             feature_block_kind};
         sel_to:   nxt_rd = {link_timeout_count_ff, 8'h00};
         sel_stat: nxt_rd = {28'h0000000, wide_id_supported,
                             host_locked_ff, run_ff, expired_ff};
         default:  nxt_rd = `ECSR_ZERO_WORD;
      endcase
   end

   // data stands only in the cycle after the strobe
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         rd_data_ff <= `ECSR_ZERO_WORD;
      end else if (rd_stb) begin
         rd_data_ff <= nxt_rd;
      end else begin
         rd_data_ff <= `ECSR_ZERO_WORD;
      end
   end

endmodule

// *** tb/ecsr_bank_assertions.sv ***
// timing checks for the identifier register bank
// assumes single-cycle strobes sampled on mclk
`timescale 1ns/10ps
`include "ecsr_map.vh"
module ecsr_bank_chk (
   // clock and reset
   input wire        mclk,
   input wire        reset,
   // register port
   input wire [15:0] addr,
   input wire [31:0] wr_data,
   input wire        wr_stb,
   input wire        rd_stb,
   input wire [31:0] rd_data_ff,
   // configuration and timer
   input wire [2:0]  addr_mode,
   input wire [15:0] feature_block_kind,
   input wire        link_evt_start,
   input wire        link_evt_done,
   input wire        link_timeout_ff,
   // stored values
   input wire [15:0] host_owner_id_ff,
   input wire        host_locked_ff,
   input wire [23:0] link_timeout_count_ff
);
   // ****
   // checks
   // ****
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   wire rd_id = rd_stb && addr == `ECSR_OFS_NODE_ID;
   wire rd_lk = rd_stb && addr == `ECSR_OFS_HOST_LOCK;
   wire wr_lk = wr_stb && addr == `ECSR_OFS_HOST_LOCK;
   wire m34 = addr_mode == `ECSR_MODE_34;
   sequence one_tick_run;
      (link_evt_start && !link_evt_done &&
       link_timeout_count_ff == `ECSR_ONE_CNT)
      ##1 (!link_evt_start && !link_evt_done) [*6];
   endsequence
   hdr_rd_a: assert property (rd_stb && addr == `ECSR_OFS_BLK_HEADER |=>
      rd_data_ff == {`ECSR_NEXT_BLOCK_PTR, $past(feature_block_kind)})
      else $error("header read wrong");
   lt_rd_a: assert property (rd_stb && addr == `ECSR_OFS_LINK_TO |=>
      rd_data_ff == {$past(link_timeout_count_ff), 8'h00})
      else $error("time-out read wrong");
   lt_wr_a: assert property (wr_stb && addr == `ECSR_OFS_LINK_TO |=>
      {link_timeout_count_ff, 8'h00} == ($past(wr_data) & 32'hFFFFFF00))
      else $error("time-out write lost");
   lock_rd_a: assert property (rd_lk |=>
      rd_data_ff == {16'h0000, $past(host_owner_id_ff)})
      else $error("lock read wrong");
   lock_set_a: assert property (wr_lk && !host_locked_ff |=> host_locked_ff &&
      {16'h0000, host_owner_id_ff} == ($past(wr_data) & 32'h0000FFFF))
      else $error("first lock write lost");
   lock_hold_a: assert property (host_locked_ff |=>
      host_locked_ff && $stable(host_owner_id_ff))
      else $error("locked id changed");
   id_top_a: assert property (rd_id |=> rd_data_ff[31:24] == 8'h00)
      else $error("id reserved bits set");
   hi34_rd_a: assert property (rd_stb && m34 &&
      addr == `ECSR_OFS_BASE_HIGH |=> rd_data_ff == 32'h00000000)
      else $error("base high visible in 34-bit");
   lo34_rd_a: assert property (rd_stb && m34 &&
      addr == `ECSR_OFS_BASE_LOW |=> !rd_data_ff[31])
      else $error("base low bit 31 in 34-bit");
   lt_fire_a: assert property (one_tick_run |-> ##[0:1] link_timeout_ff)
      else $error("one-count time-out missing");
   lock_c: cover property (wr_lk && !host_locked_ff);
   fire_c: cover property (one_tick_run);
   hdr_c: cover property (rd_stb && addr == `ECSR_OFS_BLK_HEADER);
endmodule
bind ecsr_bank ecsr_bank_chk u_chk (.mclk(mclk), .reset(reset),
   .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
   .rd_data_ff(rd_data_ff), .addr_mode(addr_mode),
   .feature_block_kind(feature_block_kind), .link_evt_start(link_evt_start),
   .link_evt_done(link_evt_done), .link_timeout_ff(link_timeout_ff),
   .host_owner_id_ff(host_owner_id_ff), .host_locked_ff(host_locked_ff),
   .link_timeout_count_ff(link_timeout_count_ff));

// *** tb/endpoint_id_csr_bank_tb.sv ***
// self-checking bench for the identifier register bank
// assumes read data one cycle after the strobe
`timescale 1ns/10ps
`include "ecsr_map.vh"
module endpoint_id_csr_bank_tb;
   // ****
   // bench
   // ****
   reg         mclk, reset, wr_stb, rd_stb, evt_s, evt_d;
   reg  [15:0] addr, kind;
   reg  [31:0] wr_data;
   reg  [2:0]  mode;
   wire [31:0] rd_data;
   wire        lto;
   wire [7:0]  sid;
   wire [15:0] wid;
   wire [31:0] bhi, blo, tag;
   integer     err_total, tests_run, i, n;
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   ecsr_bank dut (.mclk(mclk), .reset(reset), .addr(addr),
      .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rd_data_ff(rd_data), .addr_mode(mode), .wide_id_supported(1'b1),
      .feature_block_kind(kind), .link_evt_start(evt_s),
      .link_evt_done(evt_d), .link_timeout_ff(lto),
      .config_space_base_high_ff(bhi), .config_space_base_low_ff(blo),
      .small_node_id_ff(sid), .wide_node_id_ff(wid), .host_owner_id_ff(),
      .host_locked_ff(), .software_unit_tag_ff(tag),
      .link_timeout_count_ff());
   task chk(input [31:0] got, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("BAD %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [15:0] a, input [31:0] d);
      begin
         @(posedge mclk);
         addr <= a;
         wr_data <= d;
         wr_stb <= 1'b1;
         @(posedge mclk);
         wr_stb <= 1'b0;
      end
   endtask
   task rd(input [15:0] a, input [31:0] e);
      begin
         @(posedge mclk);
         addr <= a;
         rd_stb <= 1'b1;
         @(posedge mclk);
         rd_stb <= 1'b0;
         #1 chk(rd_data, e);
      end
   endtask
   // fixed window: a one-count run fires well inside it
   task fire(input [31:0] want);
      begin
         @(posedge mclk);
         evt_s <= 1'b1;
         @(posedge mclk);
         evt_s <= 1'b0;
         n = 0;
         for (i = 0; i < 12; i = i + 1) begin
            @(posedge mclk);
            #1 n = n + (lto === 1'b1);
         end
         chk(n, want);
      end
   endtask
   task t_reset;
      begin
         rd(`ECSR_OFS_BASE_HIGH, 32'h00000000);
         rd(`ECSR_OFS_BASE_LOW, 32'h00000000);
         rd(`ECSR_OFS_NODE_ID, 32'h00FFFFFF);
         rd(`ECSR_OFS_HOST_LOCK, 32'h00000FFF);
         rd(`ECSR_OFS_SW_TAG, 32'h00000000);
         rd(`ECSR_OFS_LINK_TO, 32'hFFFFFF00);
      end
   endtask
   task t_ids;
      begin
         wr(`ECSR_OFS_NODE_ID, 32'hFFA51234);
         rd(`ECSR_OFS_NODE_ID, 32'h00A51234);
         chk({24'h000000, sid}, 32'h000000A5);
         chk({16'h0000, wid}, 32'h00001234);
         wr(`ECSR_OFS_SW_TAG, 32'hFFFFFFFF);
         rd(`ECSR_OFS_SW_TAG, 32'hFFFFFFFF);
         chk(tag, 32'hFFFFFFFF);
         wr(16'h1064, 32'hFFFFFFFF);
         rd(16'h1064, 32'h00000000);
      end
   endtask
   task t_lock;
      begin
         wr(`ECSR_OFS_HOST_LOCK, 32'hFFFF1234);
         rd(`ECSR_OFS_HOST_LOCK, 32'h00001234);
         wr(`ECSR_OFS_HOST_LOCK, 32'h00005678);
         rd(`ECSR_OFS_HOST_LOCK, 32'h00001234);
      end
   endtask
   task t_base;
      begin
         for (i = 0; i < 3; i = i + 1) begin
            @(posedge mclk);
            mode <= 3'h1 << i;
            wr(`ECSR_OFS_BASE_HIGH, 32'hFFFFFFFF);
            wr(`ECSR_OFS_BASE_LOW, 32'hFFFFFFFF);
            rd(`ECSR_OFS_BASE_HIGH, i == 2 ? 32'h7FFFFFFF :
               i == 1 ? 32'h00007FFF : 32'h00000000);
            rd(`ECSR_OFS_BASE_LOW, i == 0 ? 32'h7FFFFFFF :
               32'hFFFFFFFF);
            chk(bhi, i == 2 ? 32'h7FFFFFFF :
               i == 1 ? 32'h00007FFF : 32'h00000000);
            chk(blo, i == 0 ? 32'h7FFFFFFF : 32'hFFFFFFFF);
         end
      end
   endtask
   task t_hdr;
      begin
         for (i = 1; i < 4; i = i + 1) begin
            @(posedge mclk);
            kind <= i[15:0];
            rd(`ECSR_OFS_BLK_HEADER, i);
         end
      end
   endtask
   task t_link;
      begin
         wr(`ECSR_OFS_LINK_TO, 32'h000001FF);
         rd(`ECSR_OFS_LINK_TO, 32'h00000100);
         fire(1);
         // status: wide id, locked, idle, expired
         rd(`ECSR_OFS_LINK_STAT, 32'h0000000D);
         wr(`ECSR_OFS_LINK_STAT, 32'h00000001);
         rd(`ECSR_OFS_LINK_STAT, 32'h0000000C);
         wr(`ECSR_OFS_LINK_TO, 32'h00000000);
         fire(0);
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d errors %0d", tests_run, err_total);
         if (err_total == 0 && tests_run > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   initial begin
      reset = 1'b1;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      evt_s = 1'b0;
      evt_d = 1'b0;
      addr = 16'h0000;
      wr_data = 32'h00000000;
      mode = 3'h1;
      kind = 16'h0001;
      err_total = 0;
      tests_run = 0;
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      t_reset;
      t_ids;
      t_lock;
      t_base;
      t_hdr;
      t_link;
      report_and_stop;
   end
endmodule
